// ### include/sasp_regs.svh
`ifndef SASP_REGS_SVH
`define SASP_REGS_SVH
// ==========================================================
// Register addresses
`define SASP_ADDR_RESULT   16'hff1a
`define SASP_ADDR_MODE     16'hff6c
`define SASP_ADDR_CHAN     16'hff6d
`define SASP_ADDR_CMPMODE  16'hff6e
`define SASP_ADDR_THRESH   16'hff6f
// ==========================================================
// Reset values and write masks
`define SASP_RST_REG8      8'h00
`define SASP_MASK_MODE     8'hbf
`define SASP_MASK_CHAN     8'hf7
`define SASP_MASK_CMPMODE  8'hc0
// ==========================================================
// Field positions
`define SASP_MODE_RUN      7
`define SASP_MODE_TIME_HI  5
`define SASP_MODE_TIME_LO  1
`define SASP_MODE_BOOST    0
`define SASP_CHAN_EDGE_HI  7
`define SASP_CHAN_EDGE_LO  6
`define SASP_CHAN_HWTRG    5
`define SASP_CHAN_TIMER    4
`define SASP_CHAN_SEL_HI   2
`define SASP_CMP_ENABLE    7
`define SASP_CMP_SENSE     6
// ==========================================================
// Result layout and search start
`define SASP_RESULT_PAD    6'h00
`define SASP_SAR_MSB       10'h200
`define SASP_SAR_TOP_BIT   4'h9
// ==========================================================
// Conversion times in system clocks, per time-select code
`define SASP_TCONV_96      8'd96
`define SASP_TCONV_72      8'd72
`define SASP_TCONV_48      8'd48
`define SASP_TCONV_24      8'd24
`define SASP_TCONV_224     8'd224
`define SASP_TCONV_168     8'd168
`define SASP_TCONV_112     8'd112
`define SASP_TCONV_56      8'd56
`define SASP_TCONV_54      8'd54
`define SASP_TCONV_36      8'd36
`define SASP_TCONV_18      8'd18
`define SASP_STEP_DIV      8'd12
`define SASP_STEP_MIN      8'd3
`define SASP_BITS_PER_CONV 8'd10
`endif

// ### include/sasp_pkg.sv
package sasp_pkg;
  // ========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    SASP_IDLE      = 4'b0001,
    SASP_WAIT_TRIG = 4'b0010,
    SASP_SAMPLE    = 4'b0100,
    SASP_CONVERT   = 4'b1000
  } sasp_state_t;
endpackage : sasp_pkg

// ### core/sasp_sequencer.sv
// What this block does
// - Every finished conversion overwrites the result register with the approximation value.
// - Result is left-justified ten bits; low six bits always read zero.
// - Upper eight result bits sit at the higher byte, lower two at top of lower.
// - Reset leaves the result register undefined, not cleared.
// - Reading the result, or writing mode, channel, compare or threshold, adds a wait.
// - Compare-enable low: done interrupt every conversion; high: threshold gating.
// - Sense low: interrupt when upper bits at least threshold; high: when below.
// - Full eight-bit threshold compared unsigned against upper eight result bits.
// - Each conversion samples for a fixed time, then holds until finished.
// - Binary search from bit nine at half reference down through bit zero.
// - After the tenth comparison latch result and raise done in the same step.
// - Software trigger mode repeats conversions while the run bit stays set.
// - Clearing run stops; setting it again with boost on restarts directly.
// - Software mode: register write during conversion aborts and restarts it.
// - Hardware-trigger select low: conversion begins once run is written one.
// - External mode: after run, convert once per selected pin edge.
// - External mode: edges during a conversion are ignored.
// - Hardware modes: register write during conversion aborts, back to waiting.
// - Timer mode: after run, convert once per timer event.
// - Timer mode: event during conversion aborts and restarts it.
// - Edge field: 00 none, 01 falling, 10 rising, 11 both edges.
`include "sasp_regs.svh"

module sasp_sequencer
  import sasp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Processor register port
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [15:0] bus_rdata,
  output logic             bus_wait,
  // Analog front end
  input  wire logic        comp_ge,
  output logic             sample_hold,
  output logic      [9:0]  tap_code,
  output logic      [2:0]  channel_sel,
  output logic             boost_enable,
  // Trigger sources
  input  wire logic        external_trigger_pin,
  input  wire logic        timer_trigger_event,
  // Interrupt request
  output logic             conversion_done_irq
);

  // ========================================================
  // Registers
  logic [7:0]  converter_mode_reg, next_converter_mode_reg;
  logic [7:0]  channel_select_reg, next_channel_select_reg;
  logic [7:0]  threshold_compare_mode, next_threshold_compare_mode;
  logic [7:0]  threshold_value, next_threshold_value;
  logic [15:0] conversion_result, next_conversion_result;
  logic        waited, next_waited;
  logic [15:0] next_bus_rdata;
  logic        run_bit, reference_boost_bit, hardware_trigger_select;
  logic        timer_source_select, compare_enable, compare_sense;
  logic [1:0]  edge_sel;
  logic        acc_slow, wr_go, rd_go, reg_touch;

  assign run_bit                 = converter_mode_reg[`SASP_MODE_RUN];
  assign reference_boost_bit     = converter_mode_reg[`SASP_MODE_BOOST];
  assign hardware_trigger_select = channel_select_reg[`SASP_CHAN_HWTRG];
  assign timer_source_select     = channel_select_reg[`SASP_CHAN_TIMER];
  assign edge_sel = channel_select_reg[`SASP_CHAN_EDGE_HI:`SASP_CHAN_EDGE_LO];
  assign compare_enable          = threshold_compare_mode[`SASP_CMP_ENABLE];
  assign compare_sense           = threshold_compare_mode[`SASP_CMP_SENSE];

  // Slow accesses take one extra cycle before they complete
  always_comb begin
    acc_slow = 1'b0;
    if (bus_rd && bus_addr == `SASP_ADDR_RESULT) begin
      acc_slow = 1'b1;
    end else if (bus_wr && (bus_addr == `SASP_ADDR_MODE || bus_addr == `SASP_ADDR_CHAN ||
                 bus_addr == `SASP_ADDR_CMPMODE || bus_addr == `SASP_ADDR_THRESH)) begin
      acc_slow = 1'b1;
    end
  end

  assign bus_wait  = acc_slow && !waited;
  assign wr_go     = bus_wr && !bus_wait;
  assign rd_go     = bus_rd && !bus_wait;
  assign reg_touch = wr_go && (bus_addr == `SASP_ADDR_MODE || bus_addr == `SASP_ADDR_CHAN ||
                     bus_addr == `SASP_ADDR_CMPMODE || bus_addr == `SASP_ADDR_THRESH);

  // ========================================================
  // Synchronisers and trigger edge detection
  logic       pin_meta, pin_sync, pin_prev;
  logic       comp_meta, comp_sync;
  logic       ext_edge;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pin_meta  <= 1'b0;
      pin_sync  <= 1'b0;
      pin_prev  <= 1'b0;
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      pin_meta  <= external_trigger_pin;
      pin_sync  <= pin_meta;
      pin_prev  <= pin_sync;
      comp_meta <= comp_ge;
      comp_sync <= comp_meta;
    end
  end

  always_comb begin
    case (edge_sel)
      2'b01:   ext_edge = pin_prev && !pin_sync;
      2'b10:   ext_edge = !pin_prev && pin_sync;
      2'b11:   ext_edge = pin_prev != pin_sync;
      default: ext_edge = 1'b0;
    endcase
  end

  // ========================================================
  // Conversion timing from the time-select code
  logic [7:0] tconv, step_cyc, sample_cyc, step_raw;

  always_comb begin
    case (converter_mode_reg[`SASP_MODE_TIME_HI:`SASP_MODE_TIME_LO])
      5'b00001: tconv = `SASP_TCONV_96;
      5'b00101: tconv = `SASP_TCONV_72;
      5'b01001: tconv = `SASP_TCONV_48;
      5'b01101: tconv = `SASP_TCONV_24;
      5'b10001: tconv = `SASP_TCONV_224;
      5'b10101: tconv = `SASP_TCONV_168;
      5'b11001: tconv = `SASP_TCONV_112;
      5'b11101: tconv = `SASP_TCONV_56;
      5'b00010: tconv = `SASP_TCONV_72;
      5'b00110: tconv = `SASP_TCONV_54;
      5'b01010: tconv = `SASP_TCONV_36;
      5'b01110: tconv = `SASP_TCONV_18;
      default:  tconv = `SASP_TCONV_96;
    endcase
    step_raw = tconv / `SASP_STEP_DIV;
    step_cyc = (step_raw < `SASP_STEP_MIN) ? `SASP_STEP_MIN : step_raw;
    if (tconv >= 8'(step_cyc * `SASP_BITS_PER_CONV) + `SASP_STEP_MIN) begin
      sample_cyc = tconv - 8'(step_cyc * `SASP_BITS_PER_CONV);
    end else begin
      sample_cyc = `SASP_STEP_MIN;
    end
  end

  // ========================================================
  // Sequencer
  sasp_state_t state, next_state;
  logic [7:0]  cnt, next_cnt;
  logic [3:0]  bit_idx, next_bit_idx;
  logic [9:0]  approximation_register, next_approximation_register;
  logic        next_done_irq;
  logic [9:0]  bit_mask, final_sar;
  logic        conv_done, busy, irq_cond;

  assign busy      = state == SASP_SAMPLE || state == SASP_CONVERT;
  assign bit_mask  = 10'(10'h001 << bit_idx);
  assign final_sar = comp_sync ? approximation_register
                               : (approximation_register & ~bit_mask);
  assign conv_done = state == SASP_CONVERT && cnt == 8'h00 && bit_idx == 4'h0 &&
                     run_bit && !reg_touch &&
                     !(hardware_trigger_select && timer_source_select && timer_trigger_event);

  always_comb begin
    if (!compare_enable) begin
      irq_cond = 1'b1;
    end else if (!compare_sense) begin
      irq_cond = final_sar[9:2] >= threshold_value;
    end else begin
      irq_cond = final_sar[9:2] < threshold_value;
    end
  end

  always_comb begin
    next_state                  = state;
    next_cnt                    = cnt;
    next_bit_idx                = bit_idx;
    next_approximation_register = approximation_register;
    next_done_irq               = 1'b0;
    case (state)
      SASP_IDLE: begin
        if (run_bit) begin
          next_cnt   = sample_cyc - 8'h01;
          next_state = hardware_trigger_select ? SASP_WAIT_TRIG : SASP_SAMPLE;
        end
      end
      SASP_WAIT_TRIG: begin
        if ((!timer_source_select && ext_edge) ||
            (timer_source_select && timer_trigger_event)) begin
          next_cnt   = sample_cyc - 8'h01;
          next_state = SASP_SAMPLE;
        end
      end
      SASP_SAMPLE: begin
        if (cnt == 8'h00) begin
          next_state                  = SASP_CONVERT;
          next_bit_idx                = `SASP_SAR_TOP_BIT;
          next_approximation_register = `SASP_SAR_MSB;
          next_cnt                    = step_cyc - 8'h01;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      SASP_CONVERT: begin
        if (cnt != 8'h00) begin
          next_cnt = cnt - 8'h01;
        end else if (bit_idx != 4'h0) begin
          next_approximation_register = final_sar | (bit_mask >> 1);
          next_bit_idx                = bit_idx - 4'h1;
          next_cnt                    = step_cyc - 8'h01;
        end else begin
          next_approximation_register = final_sar;
          next_done_irq               = irq_cond;
          next_cnt                    = sample_cyc - 8'h01;
          next_state = hardware_trigger_select ? SASP_WAIT_TRIG : SASP_SAMPLE;
        end
      end
      default: next_state = SASP_IDLE;
    endcase
    // External edges during a conversion fall through unseen
    // An abort in the finishing cycle also drops that cycle's interrupt
    if (busy && hardware_trigger_select && timer_source_select && timer_trigger_event) begin
      next_state    = SASP_SAMPLE;
      next_cnt      = sample_cyc - 8'h01;
      next_done_irq = 1'b0;
    end
    if (busy && reg_touch) begin
      next_cnt      = sample_cyc - 8'h01;
      next_state = hardware_trigger_select ? SASP_WAIT_TRIG : SASP_SAMPLE;
      next_done_irq = 1'b0;
    end
    if (!run_bit) begin
      next_state    = SASP_IDLE;
      next_done_irq = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state                  <= SASP_IDLE;
      cnt                    <= 8'h00;
      bit_idx                <= 4'h0;
      approximation_register <= 10'h000;
      conversion_done_irq    <= 1'b0;
    end else begin
      state                  <= next_state;
      cnt                    <= next_cnt;
      bit_idx                <= next_bit_idx;
      approximation_register <= next_approximation_register;
      conversion_done_irq    <= next_done_irq;
    end
  end

  // ========================================================
  // Register file
  always_comb begin
    next_converter_mode_reg     = converter_mode_reg;
    next_channel_select_reg     = channel_select_reg;
    next_threshold_compare_mode = threshold_compare_mode;
    next_threshold_value        = threshold_value;
    next_waited                 = bus_wait;
    next_bus_rdata              = bus_rdata;
    next_conversion_result      = conversion_result;
    if (conv_done) begin
      next_conversion_result = {final_sar, `SASP_RESULT_PAD};
    end
    if (wr_go) begin
      if (bus_addr == `SASP_ADDR_MODE) begin
        next_converter_mode_reg = bus_wdata & `SASP_MASK_MODE;
      end else if (bus_addr == `SASP_ADDR_CHAN) begin
        next_channel_select_reg = bus_wdata & `SASP_MASK_CHAN;
      end else if (bus_addr == `SASP_ADDR_CMPMODE) begin
        next_threshold_compare_mode = bus_wdata & `SASP_MASK_CMPMODE;
      end else if (bus_addr == `SASP_ADDR_THRESH) begin
        next_threshold_value = bus_wdata;
      end
    end
    if (rd_go) begin
      if (bus_addr == `SASP_ADDR_RESULT) begin
        next_bus_rdata = conversion_result;
      end else if (bus_addr == `SASP_ADDR_MODE) begin
        next_bus_rdata = {8'h00, converter_mode_reg};
      end else if (bus_addr == `SASP_ADDR_CHAN) begin
        next_bus_rdata = {8'h00, channel_select_reg};
      end else if (bus_addr == `SASP_ADDR_CMPMODE) begin
        next_bus_rdata = {8'h00, threshold_compare_mode};
      end else if (bus_addr == `SASP_ADDR_THRESH) begin
        next_bus_rdata = {8'h00, threshold_value};
      end else begin
        next_bus_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      converter_mode_reg     <= `SASP_RST_REG8;
      channel_select_reg     <= `SASP_RST_REG8;
      threshold_compare_mode <= `SASP_RST_REG8;
      threshold_value        <= `SASP_RST_REG8;
      waited                 <= 1'b0;
      bus_rdata              <= 16'h0000;
    end else begin
      converter_mode_reg     <= next_converter_mode_reg;
      channel_select_reg     <= next_channel_select_reg;
      threshold_compare_mode <= next_threshold_compare_mode;
      threshold_value        <= next_threshold_value;
      waited                 <= next_waited;
      bus_rdata              <= next_bus_rdata;
    end
  end

  // Result keeps its contents through reset
  always_ff @(posedge clk_sys) begin
    conversion_result <= next_conversion_result;
  end

  // ========================================================
  // Analog front-end drive
  assign sample_hold  = state == SASP_SAMPLE;
  assign tap_code     = approximation_register;
  assign channel_sel  = channel_select_reg[`SASP_CHAN_SEL_HI:0];
  assign boost_enable = reference_boost_bit;

  // ========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_result_latch;
    conv_done |=> conversion_result == {$past(final_sar), 6'h00};
  endproperty
  a_result_latch: assert property (p_result_latch)
    else $error("result not latched at conversion end");

  property p_irq_plain;
    conv_done && !compare_enable |=> conversion_done_irq;
  endproperty
  a_irq_plain: assert property (p_irq_plain)
    else $error("done interrupt missing in plain mode");

  property p_irq_compare;
    conv_done && compare_enable |=>
      conversion_done_irq == ($past(compare_sense) ?
        ($past(final_sar[9:2]) < $past(threshold_value)) :
        ($past(final_sar[9:2]) >= $past(threshold_value)));
  endproperty
  a_irq_compare: assert property (p_irq_compare)
    else $error("threshold gating wrong");

  property p_irq_cause;
    conversion_done_irq |-> $past(conv_done);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without conversion end");

  property p_wait_slow;
    bus_rd && bus_addr == `SASP_ADDR_RESULT && !waited |-> bus_wait ##1 !bus_wait;
  endproperty
  a_wait_slow: assert property (p_wait_slow)
    else $error("result read wait wrong");

  property p_sw_repeat;
    conv_done && !hardware_trigger_select |=> state == SASP_SAMPLE && sample_hold;
  endproperty
  a_sw_repeat: assert property (p_sw_repeat)
    else $error("software mode did not repeat");

  property p_hw_wait;
    conv_done && hardware_trigger_select |=> state == SASP_WAIT_TRIG;
  endproperty
  a_hw_wait: assert property (p_hw_wait)
    else $error("hardware mode did not wait");

  property p_stop;
    !run_bit |=> state == SASP_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("clearing run did not stop");

  property p_ext_ignore;
    state == SASP_CONVERT && cnt != 8'h00 && hardware_trigger_select && !timer_source_select
      && ext_edge && run_bit && !reg_touch |=> state == SASP_CONVERT;
  endproperty
  a_ext_ignore: assert property (p_ext_ignore)
    else $error("external edge disturbed conversion");

  property p_timer_restart;
    busy && hardware_trigger_select && timer_source_select && timer_trigger_event
      && run_bit && !reg_touch |=> state == SASP_SAMPLE && cnt == $past(sample_cyc) - 8'h01;
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("timer event did not restart");

  property p_abort;
    busy && reg_touch && run_bit && hardware_trigger_select |=>
      state == SASP_WAIT_TRIG || state == SASP_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("write did not abort to waiting");

  property p_search_start;
    state == SASP_SAMPLE && cnt == 8'h00 && run_bit && !reg_touch && !timer_trigger_event
      |=> state == SASP_CONVERT && tap_code == 10'h200 && !sample_hold;
  endproperty
  a_search_start: assert property (p_search_start)
    else $error("search did not start at half reference");

  c_done_plain:  cover property (conv_done && !compare_enable);
  c_done_gated:  cover property (conv_done && compare_enable && !irq_cond);
  c_ext_start:   cover property (state == SASP_WAIT_TRIG && ext_edge && !timer_source_select);
  c_timer_abort: cover property (busy && timer_source_select && timer_trigger_event);

endmodule : sasp_sequencer

// ### test/sasp_analog_model.sv
module sasp_analog_model (
  // Clock
  input  wire logic       clk_sys,
  // Front end control from the sequencer
  input  wire logic       sample_hold,
  input  wire logic [9:0] tap_code,
  // Input level as a code
  input  wire logic [9:0] vin_code,
  // Comparator output
  output logic            comp_ge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  // ========================================================
  // Track while sampling, freeze while holding
  always_ff @(posedge clk_sys) begin
    if (sample_hold) begin
      held <= vin_code;
    end
  end
  assign comp_ge = (held >= tap_code);
endmodule : sasp_analog_model

// ### test/testbench.sv
`include "sasp_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_b, bus_wr, bus_rd, bus_wait, comp_ge, sample_hold, boost_enable;
  logic        ext_pin, tmr_evt, irq;
  logic [15:0] bus_addr, bus_rdata;
  logic [7:0]  bus_wdata;
  logic [9:0]  tap_code, vin;
  logic [2:0]  channel_sel;
  int          err_total = 0, tests_run = 0, irqs = 0;
  sasp_sequencer sasp_sequencer_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bus_wait(bus_wait), .comp_ge(comp_ge), .sample_hold(sample_hold), .tap_code(tap_code),
    .channel_sel(channel_sel), .boost_enable(boost_enable), .external_trigger_pin(ext_pin),
    .timer_trigger_event(tmr_evt), .conversion_done_irq(irq));
  sasp_analog_model sasp_analog_model_i (.clk_sys(clk_sys), .sample_hold(sample_hold),
    .tap_code(tap_code), .vin_code(vin), .comp_ge(comp_ge));
  // ========================================================
  // Clock and interrupt pulse counter
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (irq === 1'b1) irqs <= irqs + 1;
  end
  // ========================================================
  // Common tasks
  task automatic test_done;
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : idle
  // Holds the request until the edge that sees no wait, then releases
  task automatic bus_op(input logic wr, input logic [15:0] a, input logic [7:0] d,
                        output logic [15:0] q, output int nw);
    logic w;
    nw = 0;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = wr;
    bus_rd = !wr;
    forever begin
      #1 w = bus_wait;
      @(posedge clk_sys);
      @(negedge clk_sys);
      if (w === 1'b0) break;
      nw++;
    end
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    q = bus_rdata;
    // Let an edge pass so a following call never re-raises a strobe in one step
    @(negedge clk_sys);
  endtask : bus_op
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    logic [15:0] q;
    int          nw;
    bus_op(1'b1, a, d, q, nw);
  endtask : wr8
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input int waits);
    logic [15:0] q;
    int          nw;
    bus_op(1'b0, a, 8'h00, q, nw);
    check(q, exp);
    check(16'(nw), 16'(waits));
  endtask : rd_chk
  task automatic wait_irq(input int lim, output int n);
    int base;
    base = irqs;
    n = 0;
    while (irqs == base && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_irq
  task automatic chk_time(input int lo);
    int n;
    wait_irq(130, n);
    check({15'h0, n >= lo && n <= 101}, 16'h0001);
  endtask : chk_time
  task automatic pulse_tmr;
    tmr_evt = 1'b1;
    @(negedge clk_sys);
    tmr_evt = 1'b0;
  endtask : pulse_tmr
  // ========================================================
  // Scenarios
  task automatic t_regs;
    rd_chk(`SASP_ADDR_CMPMODE, 16'h0000, 0);
    rd_chk(`SASP_ADDR_THRESH, 16'h0000, 0);
    wr8(`SASP_ADDR_CMPMODE, 8'hff);
    rd_chk(`SASP_ADDR_CMPMODE, 16'h00c0, 0);
    wr8(`SASP_ADDR_CMPMODE, 8'h00);
    rd_chk(16'hff1b, 16'h0000, 0);
    wr8(`SASP_ADDR_CHAN, 8'h0b);
    rd_chk(`SASP_ADDR_CHAN, 16'h0003, 0);
    check({13'h0, channel_sel}, 16'h0003);
  endtask : t_regs
  task automatic t_soft;
    int n0;
    wr8(`SASP_ADDR_CHAN, 8'h00);
    wr8(`SASP_ADDR_MODE, 8'h03);
    check({15'h0, boost_enable}, 16'h0001);
    idle(50);
    wr8(`SASP_ADDR_MODE, 8'h83);
    chk_time(96);
    rd_chk(`SASP_ADDR_RESULT, 16'ha940, 1);
    chk_time(93);
    wr8(`SASP_ADDR_MODE, 8'h01);
    n0 = irqs;
    wr8(`SASP_ADDR_RESULT, 8'h00);
    idle(150);
    check(16'(irqs - n0), 16'h0000);
    rd_chk(`SASP_ADDR_RESULT, 16'ha940, 1);
    wr8(`SASP_ADDR_MODE, 8'h83);
    idle(50);
    wr8(`SASP_ADDR_THRESH, 8'h00);
    chk_time(94);
    wr8(`SASP_ADDR_MODE, 8'h01);
    idle(5);
  endtask : t_soft
  task automatic t_compare;
    logic [7:0] cm [5] = '{8'h80, 8'h80, 8'hc0, 8'hc0, 8'h00};
    logic [7:0] th [5] = '{8'ha9, 8'haa, 8'haa, 8'ha9, 8'hff};
    logic [4:0] hit = 5'b10101;
    int         n0;
    for (int i = 0; i < 5; i++) begin
      wr8(`SASP_ADDR_THRESH, th[i]);
      wr8(`SASP_ADDR_CMPMODE, cm[i]);
      n0 = irqs;
      wr8(`SASP_ADDR_MODE, 8'h83);
      idle(110);
      wr8(`SASP_ADDR_MODE, 8'h01);
      check(16'(irqs - n0), {15'h0, hit[4 - i]});
    end
    wr8(`SASP_ADDR_CMPMODE, 8'h00);
  endtask : t_compare
  task automatic t_external;
    int exp [4] = '{0, 2, 1, 2};
    int n0;
    for (int c = 0; c < 4; c++) begin
      wr8(`SASP_ADDR_CHAN, {2'(c), 6'h20});
      wr8(`SASP_ADDR_MODE, 8'h83);
      n0 = irqs;
      idle(20);
      ext_pin = 1'b1;
      idle(30);
      ext_pin = 1'b0;
      idle(10);
      ext_pin = 1'b1;
      idle(150);
      ext_pin = 1'b0;
      idle(150);
      check(16'(irqs - n0), 16'(exp[c]));
      wr8(`SASP_ADDR_MODE, 8'h01);
    end
    wr8(`SASP_ADDR_CHAN, 8'ha0);
    wr8(`SASP_ADDR_MODE, 8'h83);
    n0 = irqs;
    ext_pin = 1'b1;
    idle(30);
    wr8(`SASP_ADDR_THRESH, 8'h00);
    idle(200);
    ext_pin = 1'b0;
    check(16'(irqs - n0), 16'h0000);
    wr8(`SASP_ADDR_MODE, 8'h01);
  endtask : t_external
  task automatic t_timer;
    int n0;
    wr8(`SASP_ADDR_CHAN, 8'h30);
    wr8(`SASP_ADDR_MODE, 8'h83);
    idle(20);
    pulse_tmr();
    chk_time(95);
    n0 = irqs;
    idle(150);
    pulse_tmr();
    idle(50);
    pulse_tmr();
    idle(90);
    check(16'(irqs - n0), 16'h0000);
    idle(30);
    check(16'(irqs - n0), 16'h0001);
    wr8(`SASP_ADDR_MODE, 8'h01);
  endtask : t_timer
  // ========================================================
  // Main sequence and watchdog
  initial begin
    {rst_b, bus_wr, bus_rd, ext_pin, tmr_evt} = 5'h00;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    vin = 10'h2a5;
    idle(8);
    rst_b = 1'b1;
    idle(2);
    t_regs();
    t_soft();
    t_compare();
    t_external();
    t_timer();
    test_done();
  end
  initial begin
    #(20 * 20000);
    err_total++;
    test_done();
  end
endmodule : testbench
